//--- core/plm_regs.svh
// Constants for the partition label and map register block.
`ifndef PLM_REGS_SVH
`define PLM_REGS_SVH
`define PLM_OP0_SYS        2'h3
`define PLM_SM_OP1         3'h0
`define PLM_SM_CRN         4'hA
`define PLM_SM_CRM         4'h5
`define PLM_SM_OP2         3'h3
`define PLM_VPM_OP1        3'h4
`define PLM_VPM_CRN        4'hA
`define PLM_VPM_CRM        4'h6
`define PLM_VPM_OP2        3'h0
`define PLM_EC_SYSREG      6'h18
`define PLM_SM_PARTITION_IDENTIFIER_LSB  16
`define PLM_SM_PMG_LSB     40
`define PLM_SM_KEEP_MASK   64'h0000_FF00_FFFF_0000
`define PLM_ENTRY_W        16
`define PLM_MAP_INDEX_MAX  3'h0
`endif

//--- core/plm_pkg.sv
// Types shared by the partition label and map block.
`default_nettype none
package plm_pkg;
   typedef enum logic [1:0] {PLM_EL0, PLM_EL1, PLM_EL2, PLM_EL3} plm_el_t;
   typedef enum logic [1:0] {PLM_OK, PLM_UNDEF, PLM_TRAP_EL2, PLM_TRAP_EL3} plm_result_t;
endpackage
`default_nettype wire

//--- core/plm_access_check.sv
// Combinational trap and permission checks for both registers.
`include "plm_regs.svh"
`default_nettype none
module plm_access_check
(
   input  wire  plm_pkg::plm_el_t     i_el,
   input  wire  logic                 i_is_map,
   input  wire  logic                 i_el3_present,
   input  wire  logic                 i_trap_lower_levels,
   input  wire  logic                 i_halted,
   input  wire  logic                 i_secure_debug_disable,
   input  wire  logic                 i_el2_enabled,
   input  wire  logic                 i_streaming_reg_access_enable,
   input  wire  logic                 i_virtualization_present,
   output plm_pkg::plm_result_t       o_result
);
   import plm_pkg::*;
   logic el3_trap;
   assign el3_trap = i_el3_present && i_trap_lower_levels;
   always_comb
   begin
      o_result = PLM_OK;
      if (i_is_map && !i_virtualization_present)
         o_result = PLM_UNDEF;
      else
         case (i_el)
            PLM_EL0: o_result = PLM_UNDEF;
            PLM_EL1:
               if (i_is_map)
                  o_result = PLM_UNDEF;
               else if (el3_trap)
                  o_result = (i_halted && i_secure_debug_disable) ? PLM_UNDEF
                                                                 : PLM_TRAP_EL3;
               else if (i_el2_enabled && !i_streaming_reg_access_enable)
                  o_result = PLM_TRAP_EL2;
               else
                  o_result = PLM_OK;
            PLM_EL2:
               if (el3_trap)
                  o_result = (i_halted && i_secure_debug_disable) ? PLM_UNDEF
                                                                 : PLM_TRAP_EL3;
               else
                  o_result = PLM_OK;
            PLM_EL3: o_result = PLM_OK;
            default: o_result = PLM_UNDEF;
         endcase
   end
endmodule
`default_nettype wire

//--- core/plm_label_map.sv
// Virtual to physical partition ID lookup through the first map register.
`include "plm_regs.svh"
`default_nettype none
module plm_label_map
(
   input  wire  logic [63:0]  i_map,
   input  wire  logic [3:0]   i_valid,
   input  wire  logic         i_active,
   input  wire  logic [15:0]  i_virtual_id,
   output logic       [15:0]  o_physical_id,
   output logic               o_mapped
);
   logic [15:0] entry [0:3];
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_entry
         assign entry[g] = i_map[g*`PLM_ENTRY_W +: `PLM_ENTRY_W];
      end
   endgenerate
   // Only IDs 0..3 are covered; larger IDs would need the further map registers.
   assign o_mapped = i_active && (i_virtual_id[15:2] == 14'h0000)
                     && i_valid[i_virtual_id[1:0]];
   assign o_physical_id = o_mapped ? entry[i_virtual_id[1:0]] : i_virtual_id;
endmodule
`default_nettype wire

//--- core/plm_top.sv
// System register block for the streaming label register and first map register.
`include "plm_regs.svh"
`default_nettype none
module plm_top
(
   input  wire  logic                 i_clock,
   input  wire  logic                 i_rst,
   input  wire  logic                 i_req,
   input  wire  logic                 i_write,
   input  wire  logic [1:0]           i_op0,
   input  wire  logic [2:0]           i_op1,
   input  wire  logic [3:0]           i_crn,
   input  wire  logic [3:0]           i_crm,
   input  wire  logic [2:0]           i_op2,
   input  wire  logic [63:0]          i_wdata,
   input  wire  plm_pkg::plm_el_t     i_el,
   input  wire  logic                 i_el3_present,
   input  wire  logic                 i_trap_lower_levels,
   input  wire  logic                 i_halted,
   input  wire  logic                 i_secure_debug_disable,
   input  wire  logic                 i_el2_enabled,
   input  wire  logic                 i_streaming_reg_access_enable,
   input  wire  logic                 i_virtualization_present,
   input  wire  logic                 i_el1_map_enable,
   input  wire  logic                 i_el0_map_enable,
   input  wire  logic [3:0]           i_map_entry_valid,
   input  wire  logic                 i_partitioning_enable,
   input  wire  logic                 i_lbl_req,
   input  wire  logic                 i_lbl_from_el0,
   input  wire  logic                 i_lbl_streaming,
   input  wire  logic [15:0]          i_lbl_partition_id,
   output logic                       o_ack,
   output logic [63:0]                o_rdata,
   output plm_pkg::plm_result_t       o_result,
   output logic [5:0]                 o_syndrome_class,
   output logic [2:0]                 o_map_reg_max_index,
   output logic                       o_lbl_valid,
   output logic                       o_lbl_labelled,
   output logic [15:0]                o_lbl_partition_id,
   output logic [7:0]                 o_lbl_monitor_group,
   output logic                       o_lbl_mapped
);
   import plm_pkg::*;

   logic [63:0]   streaming_label_reg;
   logic [63:0]   vpartid_map_reg0;
   logic          hit_sm;
   logic          hit_map;
   plm_result_t   chk;
   logic          map_active;
   logic [15:0]   sel_id;
   logic [15:0]   phys_id;
   logic          mapped;

   assign hit_sm  = (i_op0 == `PLM_OP0_SYS) && (i_op1 == `PLM_SM_OP1) && (i_crn == `PLM_SM_CRN)
                    && (i_crm == `PLM_SM_CRM) && (i_op2 == `PLM_SM_OP2);
   assign hit_map = (i_op0 == `PLM_OP0_SYS) && (i_op1 == `PLM_VPM_OP1)
                    && (i_crn == `PLM_VPM_CRN) && (i_crm == `PLM_VPM_CRM)
                    && (i_op2 == `PLM_VPM_OP2);

   plm_access_check u_check
   (
      .i_el                          (i_el),
      .i_is_map                      (hit_map),
      .i_el3_present                 (i_el3_present),
      .i_trap_lower_levels           (i_trap_lower_levels),
      .i_halted                      (i_halted),
      .i_secure_debug_disable        (i_secure_debug_disable),
      .i_el2_enabled                 (i_el2_enabled),
      .i_streaming_reg_access_enable (i_streaming_reg_access_enable),
      .i_virtualization_present      (i_virtualization_present),
      .o_result                      (chk)
   );

   // Reserved bits are dropped on write so they always read as zero.
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         streaming_label_reg <= 64'h0000_0000_0000_0000;
      else if (i_req && i_write && hit_sm && chk == PLM_OK)
         streaming_label_reg <= i_wdata & `PLM_SM_KEEP_MASK;
   end

   // No reset: software must program the entries before enabling mapping.
   always_ff @(posedge i_clock)
   begin
      if (i_req && i_write && hit_map && chk == PLM_OK)
         vpartid_map_reg0 <= i_wdata;
   end

   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         o_ack <= 1'b0;
      else
         o_ack <= i_req;
   end

   // The result stands until the next request so a slow consumer can still read it.
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         o_result <= PLM_OK;
      else if (i_req)
         o_result <= (hit_sm || hit_map) ? chk : PLM_UNDEF;
   end

   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         o_syndrome_class <= 6'h00;
      else if (i_req && (hit_sm || hit_map) && (chk == PLM_TRAP_EL2 || chk == PLM_TRAP_EL3))
         o_syndrome_class <= `PLM_EC_SYSREG;
      else
         o_syndrome_class <= 6'h00;
   end

   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         o_rdata <= 64'h0000_0000_0000_0000;
      else if (i_req && !i_write && (hit_sm || hit_map) && chk == PLM_OK)
         o_rdata <= hit_sm ? streaming_label_reg : vpartid_map_reg0;
      else
         o_rdata <= 64'h0000_0000_0000_0000;
   end

   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         o_map_reg_max_index <= 3'h0;
      else
         o_map_reg_max_index <= i_virtualization_present ? `PLM_MAP_INDEX_MAX : 3'h0;
   end

   // Labels are read live from the register each request, never held in a cache.
   assign sel_id     = i_lbl_streaming ? streaming_label_reg[`PLM_SM_PARTITION_IDENTIFIER_LSB +: 16]
                                       : i_lbl_partition_id;
   assign map_active = i_virtualization_present && i_el2_enabled
                       && (i_lbl_from_el0 ? i_el0_map_enable : i_el1_map_enable);

   plm_label_map u_map
   (
      .i_map         (vpartid_map_reg0),
      .i_valid       (i_map_entry_valid),
      .i_active      (map_active),
      .i_virtual_id  (sel_id),
      .o_physical_id (phys_id),
      .o_mapped      (mapped)
   );

   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         o_lbl_valid <= 1'b0;
      else
         o_lbl_valid <= i_lbl_req;
   end

   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         o_lbl_labelled <= 1'b0;
      else
         o_lbl_labelled <= i_lbl_req && i_partitioning_enable;
   end

   // A disabled label reads as zero so stale IDs never leak onto the request.
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         o_lbl_partition_id <= 16'h0000;
      else
         o_lbl_partition_id <= i_partitioning_enable ? phys_id : 16'h0000;
   end

   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         o_lbl_monitor_group <= 8'h00;
      else if (i_partitioning_enable && i_lbl_streaming)
         o_lbl_monitor_group <= streaming_label_reg[`PLM_SM_PMG_LSB +: 8];
      else
         o_lbl_monitor_group <= 8'h00;
   end

   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
         o_lbl_mapped <= 1'b0;
      else
         o_lbl_mapped <= i_lbl_req && i_partitioning_enable && mapped;
   end
endmodule
`default_nettype wire

//--- sim/plm_pipe.sv
// Pipeline side model that turns a register choice into its system encoding.
`default_nettype none
module plm_pipe
(
   input  wire logic [1:0] i_sel,
   output logic      [1:0] o_op0,
   output logic      [2:0] o_op1,
   output logic      [3:0] o_crn,
   output logic      [3:0] o_crm,
   output logic      [2:0] o_op2
);
   timeunit 1ns;
   timeprecision 1ns;
   // Choice 0 is the label register, 1 the map register, 2 and 3 spare encodings.
   always_comb
   begin
      o_op0 = 2'h3;
      o_op1 = i_sel[0] ? 3'h4 : 3'h0;
      o_crn = 4'hA;
      o_crm = i_sel[0] ? 4'h6 : 4'h5;
      o_op2 = i_sel[1] ? 3'h7 : (i_sel[0] ? 3'h0 : 3'h3);
   end
endmodule
`default_nettype wire

//--- sim/plm_properties.sv
// Concurrent checks on the ports of the partition label and map block.
`include "plm_regs.svh"
`default_nettype none
module plm_props
(
   input wire logic                 i_clock,
   input wire logic                 i_rst,
   input wire logic                 i_req,
   input wire logic [1:0]           i_op0,
   input wire logic [2:0]           i_op1,
   input wire logic [3:0]           i_crn,
   input wire logic [3:0]           i_crm,
   input wire logic [2:0]           i_op2,
   input wire plm_pkg::plm_el_t     i_el,
   input wire logic                 i_el3_present,
   input wire logic                 i_trap_lower_levels,
   input wire logic                 i_halted,
   input wire logic                 i_secure_debug_disable,
   input wire logic                 i_el2_enabled,
   input wire logic                 i_streaming_reg_access_enable,
   input wire logic                 i_virtualization_present,
   input wire logic                 i_partitioning_enable,
   input wire logic                 i_lbl_req,
   input wire logic [63:0]          o_rdata,
   input wire plm_pkg::plm_result_t o_result,
   input wire logic [5:0]           o_syndrome_class,
   input wire logic                 o_lbl_valid,
   input wire logic                 o_lbl_labelled,
   input wire logic                 o_lbl_mapped
);
   timeunit 1ns;
   timeprecision 1ns;
   import plm_pkg::*;
   logic sm, mp, t3, hs;
   assign sm = i_op0 == 2'h3 && i_op1 == 3'h0 && i_crn == 4'hA && i_crm == 4'h5 && i_op2 == 3'h3;
   assign mp = i_op0 == 2'h3 && i_op1 == 3'h4 && i_crn == 4'hA && i_crm == 4'h6 && i_op2 == 3'h0;
   assign t3 = i_el3_present && i_trap_lower_levels;
   assign hs = i_halted && i_secure_debug_disable;
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   el0_undef_a: assert property (i_req && i_el == PLM_EL0 |=> o_result == PLM_UNDEF)
      else $error("level 0 access not undefined");
   lower_trap_a: assert property (
      i_req && sm && i_el inside {PLM_EL1, PLM_EL2} && t3 && !hs
      |=> o_result == PLM_TRAP_EL3 && o_syndrome_class == 6'h18) else $error("no level 3 trap");
   halted_undef_a: assert property (i_req && sm && i_el != PLM_EL3 && t3 && hs
      |=> o_result == PLM_UNDEF) else $error("halted access not undefined");
   el2_trap_a: assert property (i_req && sm && i_el == PLM_EL1 && !t3 && i_el2_enabled
      && !i_streaming_reg_access_enable |=> o_result == PLM_TRAP_EL2) else $error("no trap to 2");
   el2_skip_en_a: assert property (
      i_req && sm && i_el == PLM_EL2 && !t3 |=> o_result == PLM_OK)
      else $error("level 2 access refused");
   el3_done_a: assert property (
      i_req && i_el == PLM_EL3 && (sm || (mp && i_virtualization_present))
      |=> o_result == PLM_OK && o_syndrome_class == 6'h0) else $error("level 3 access refused");
   map_absent_a: assert property (
      i_req && mp && !i_virtualization_present |=> o_result == PLM_UNDEF)
      else $error("absent map register answered");
   reserved_zero_a: assert property (
      i_req && sm |=> (o_rdata & ~`PLM_SM_KEEP_MASK) == 64'h0)
      else $error("reserved label bits not zero");
   label_gate_a: assert property (
      i_lbl_req |=> o_lbl_valid && o_lbl_labelled == $past(i_partitioning_enable))
      else $error("label gating wrong");
   no_el2_map_a: assert property (i_lbl_req && !i_el2_enabled |=> !o_lbl_mapped)
      else $error("mapped without level 2");
   cover property (i_req && sm ##1 o_result == PLM_TRAP_EL2);
   cover property (i_req && mp ##1 o_result == PLM_OK);
   cover property (o_lbl_valid && o_lbl_mapped);
endmodule
bind plm_top plm_props i_plm_props (.*);
`default_nettype wire

//--- sim/tb.sv
// Self-checking bench for the partition label and map block.
`include "plm_regs.svh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import plm_pkg::*;
   logic i_clock = 0, i_rst = 1, i_req = 0, i_write = 0, i_lbl_req = 0, mk = 0, m;
   logic i_el3_present = 0, i_trap_lower_levels = 0, i_halted = 0, i_secure_debug_disable = 0;
   logic i_el2_enabled = 0, i_streaming_reg_access_enable = 0, i_virtualization_present = 0;
   logic i_el1_map_enable = 0, i_el0_map_enable = 0, i_partitioning_enable = 0;
   logic i_lbl_from_el0 = 0, i_lbl_streaming = 0, o_ack, o_lbl_valid, o_lbl_labelled, o_lbl_mapped;
   logic [1:0] sel = 0, i_op0;
   logic [2:0] i_op1, i_op2, o_map_reg_max_index;
   logic [3:0] i_crn, i_crm, i_map_entry_valid = 0;
   logic [5:0] o_syndrome_class;
   logic [7:0] o_lbl_monitor_group;
   logic [15:0] i_lbl_partition_id = 0, o_lbl_partition_id, v;
   logic [31:0] r, rs = 32'h5;
   logic [63:0] i_wdata = 0, o_rdata, sm = 0, map;
   plm_el_t i_el = PLM_EL0;
   plm_result_t o_result, e;
   int n_tests = 0, num_errors = 0;
   always #20 i_clock = ~i_clock;
   plm_pipe i_plm_pipe (.i_sel(sel), .o_op0(i_op0), .o_op1(i_op1), .o_crn(i_crn),
      .o_crm(i_crm), .o_op2(i_op2));
   plm_top i_plm_top (.*);
   function automatic logic [31:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction
   // Reference answer of one access; the map register at level 1 is refused outright.
   function automatic plm_result_t exp_res();
      if (sel[1] || i_el == PLM_EL0 || sel[0] && (!i_virtualization_present || i_el == PLM_EL1))
         return PLM_UNDEF;
      if (i_el == PLM_EL3)
         return PLM_OK;
      if (i_el3_present && i_trap_lower_levels)
         return (i_halted && i_secure_debug_disable) ? PLM_UNDEF : PLM_TRAP_EL3;
      if (i_el == PLM_EL1 && i_el2_enabled && !i_streaming_reg_access_enable)
         return PLM_TRAP_EL2;
      return PLM_OK;
   endfunction
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(posedge i_clock);
      i_rst <= 1'h0;
      for (int k = 0; k < 400; k++)
      begin
         @(posedge i_clock);
         r = rnd();
         i_req <= 1'h1;
         {i_write, sel} <= r[4:2];
         i_el <= plm_el_t'(r[1:0]);
         i_wdata <= {rnd(), rnd()};
         {i_el3_present, i_trap_lower_levels, i_halted, i_secure_debug_disable, i_el2_enabled,
            i_streaming_reg_access_enable, i_virtualization_present, i_el1_map_enable,
            i_el0_map_enable, i_partitioning_enable, i_lbl_from_el0, i_lbl_streaming} <= r[16:5];
         i_map_entry_valid <= r[20:17];
         i_lbl_partition_id <= r[21] ? {14'h0, r[23:22]} : r[31:16];
         @(posedge i_clock);
         i_req <= 1'h0;
         i_lbl_req <= 1'h1;
         #1;
         e = exp_res();
         chk(o_ack, 1);
         chk(o_result, e);
         chk(o_syndrome_class, e[1] ? 6'h18 : 6'h0);
         chk(o_map_reg_max_index, `PLM_MAP_INDEX_MAX);
         if (!(sel[0] && !mk))
            chk(o_rdata, (e == PLM_OK && !i_write) ? (sel[0] ? map : sm) : 64'h0);
         if (e == PLM_OK && i_write && sel[0])
            {mk, map} = {1'h1, i_wdata};
         if (e == PLM_OK && i_write && !sel[0])
            sm = i_wdata & `PLM_SM_KEEP_MASK;
         @(posedge i_clock);
         i_lbl_req <= 1'h0;
         #1;
         v = i_lbl_streaming ? sm[31:16] : i_lbl_partition_id;
         m = i_partitioning_enable && i_virtualization_present && i_el2_enabled
            && (i_lbl_from_el0 ? i_el0_map_enable : i_el1_map_enable) && v < 16'h4
            && i_map_entry_valid[v[1:0]];
         chk(o_lbl_valid, 1);
         chk(o_lbl_labelled, i_partitioning_enable);
         chk(o_lbl_mapped, m);
         if (!m || mk)
            chk(o_lbl_partition_id, m ? map[16 * v[1:0] +: 16]
               : (i_partitioning_enable ? v : 16'h0));
         chk(o_lbl_monitor_group, (i_partitioning_enable && i_lbl_streaming)
            ? sm[47:40] : 8'h0);
      end
      conclude();
   end
endmodule
`default_nettype wire
